/* logic/pmrw_top.sv */
// Power mode controller and ring wake path of the card socket adapter.
// Assumes host bus pins are asynchronous and sys_rst follows the power good input.
//
// Summary of operation
// - Ring select bit turns pin fifteen into wake
// - Per-socket ring enable forwards card ring input
// - Card ring low drives wake output low
// - Wake stays low until next host cycle
// - Idle gating on after reset, clearing bit one disables
// - Idle gating stops clock, holds card lines
// - Activity wakes gated logic, then gates again
// - Gating invisible to host bus cycles
// - Bit two set enters software suspend
// - Suspend allows only index and mode writes
// - Suspend ignores host accesses to cards
// - Interrupts and ring pass during suspend
// - Clearing bit two resumes after fifty ms
// - Address enable high blocks all bus inputs
// - Six supply and sense pins per socket
`timescale 1ns/1ns
module pmrw_top #(
    parameter logic [pmrw_pkg::WAKE_W-1:0] WAKE_CYCLES = pmrw_pkg::WAKE_CYC_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Host bus
    input wire pmrw_pkg::pmrw_isa_in_s isa_in,
    output logic [7:0] sd_out,
    output logic sd_oe_n,
    // Interrupt pin fifteen, also the ring wake output
    output logic interrupt_pin_fifteen_out,
    output logic interrupt_pin_fifteen_oe_n,
    // Sockets
    input wire pmrw_pkg::pmrw_sock_in_s [pmrw_pkg::NSOCK-1:0] sock_in,
    output pmrw_pkg::pmrw_sock_out_s [pmrw_pkg::NSOCK-1:0] sock_out,
    // Card side logic
    input wire logic card_bus_busy,
    output logic core_clk_en,
    output logic card_access_en,
    output logic card_lines_hold
);
    import pmrw_pkg::*;

    localparam int ISA_W = $bits(pmrw_isa_in_s);
    localparam int SOCK_W = $bits(pmrw_sock_in_s);
    localparam int FILT_W = ISA_W + NSOCK * SOCK_W;

    // Index decode: socket n register sits at base plus n strides
    function automatic logic sock_hit(input logic [7:0] idx, input int sk,
                                      input logic [7:0] off);
        logic [7:0] addr;
        addr = off + 8'(sk * SOCK_STRIDE);
        return idx == addr;
    endfunction

    // Filtered pins
    logic [FILT_W-1:0] filt;
    pmrw_isa_in_s isa_f;
    pmrw_sock_in_s [NSOCK-1:0] sock_f;

    pmrw_pin_filter #(
        .W(FILT_W)
    ) u_filter (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({isa_in, sock_in}),
        .dout(filt)
    );

    assign isa_f = filt[FILT_W-1:NSOCK*SOCK_W];
    assign sock_f = filt[NSOCK*SOCK_W-1:0];

    // Registers and state
    logic [7:0] index_r;
    logic [7:0] pwr_mode_r;
    logic [7:0] card_ctrl_r [NSOCK];
    logic [7:0] sock_pwr_r [NSOCK];
    logic [3:0] strb_q_r;
    logic [NSOCK-1:0] cd_q_r;
    logic ring_latched_r;
    pmrw_pwr_e state_r;
    pmrw_pwr_e state_nxt;
    logic [WAKE_W-1:0] wake_cnt_r;
    logic [IDLE_W-1:0] idle_cnt_r;

    // Host strobes, blocked while address enable is high
    logic bus_open;
    logic [3:0] strb;
    logic [3:0] strb_start;
    logic host_cycle_start;
    logic hit_idx;
    logic hit_dat;
    logic wr_idx;
    logic wr_dat;
    logic rd_port;
    logic regs_open;

    assign bus_open = !isa_f.aen;
    assign strb = bus_open ? ~{isa_f.ior_n, isa_f.iow_n, isa_f.memr_n, isa_f.memw_n}
                           : 4'h0;
    assign strb_start = strb & ~strb_q_r;
    assign host_cycle_start = |strb_start;
    assign hit_idx = isa_f.sa == PORT_INDEX;
    assign hit_dat = isa_f.sa == PORT_DATA;
    assign wr_idx = strb_start[2] && hit_idx;
    assign wr_dat = strb_start[2] && hit_dat;
    assign rd_port = strb[3] && (hit_idx || hit_dat);
    assign regs_open = (state_r == PS_ACTIVE) || (state_r == PS_GATED);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            strb_q_r <= 4'h0;
        end
        else
        begin
            strb_q_r <= strb;
        end
    end

    // Card presence edges
    logic [NSOCK-1:0] present;
    logic [NSOCK-1:0] inserted;
    logic [NSOCK-1:0] removed;

    always_comb
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            present[s] = !sock_f[s].card_detect_n;
        end
    end

    assign inserted = present & ~cd_q_r;
    assign removed = ~present & cd_q_r;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cd_q_r <= '0;
        end
        else
        begin
            cd_q_r <= present;
        end
    end

    // Index register, open in every power state
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            index_r <= 8'h00;
        end
        else if (wr_idx)
        begin
            index_r <= isa_f.sd;
        end
    end

    // Power mode control, writable in every power state
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pwr_mode_r <= PM_RESET;
        end
        else if (wr_dat && index_r == IDX_PWR_MODE)
        begin
            pwr_mode_r <= isa_f.sd;
        end
    end

    // Card interrupt and general control per socket
    always_ff @(posedge mclk)
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            if (sys_rst)
            begin
                card_ctrl_r[s] <= CC_RESET;
            end
            else if (wr_dat && regs_open && sock_hit(index_r, s, IDX_CARD_CTRL))
            begin
                card_ctrl_r[s] <= isa_f.sd;
            end
        end
    end

    // Socket supply control: software or automatic on insertion and removal
    always_ff @(posedge mclk)
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            if (sys_rst)
            begin
                sock_pwr_r[s] <= SP_RESET;
            end
            else if (removed[s])
            begin
                sock_pwr_r[s][SP_VCC_LSB +: 2] <= 2'h0;
                sock_pwr_r[s][SP_VPP_LSB +: 2] <= 2'h0;
            end
            else if (inserted[s] && sock_pwr_r[s][SP_AUTO])
            begin
                sock_pwr_r[s][SP_VCC_LSB +: 2] <= VCC_AUTO_ON;
            end
            else if (wr_dat && regs_open && sock_hit(index_r, s, IDX_SOCK_PWR))
            begin
                sock_pwr_r[s] <= isa_f.sd;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            if (sys_rst)
            begin
                sock_out[s] <= '0;
            end
            else
            begin
                sock_out[s].vcc_en <= sock_pwr_r[s][SP_VCC_LSB +: 2];
                sock_out[s].vpp_en <= sock_pwr_r[s][SP_VPP_LSB +: 2];
            end
        end
    end

    // Ring request and card interrupt routed to pin fifteen
    logic ring_req;
    logic interrupt_pin_fifteen_req;

    always_comb
    begin
        ring_req = 1'b0;
        interrupt_pin_fifteen_req = 1'b0;
        for (int s = 0; s < NSOCK; s++)
        begin
            if (card_ctrl_r[s][CC_RING_EN] && card_ctrl_r[s][CC_IO_CARD] && present[s]
                && !sock_f[s].card_status_ring_input_n)
            begin
                ring_req = 1'b1;
            end
            if (card_ctrl_r[s][CC_IRQ_LSB +: 4] == IRQ_SEL_FIFTEEN && present[s]
                && !sock_f[s].card_irq_n)
            begin
                interrupt_pin_fifteen_req = 1'b1;
            end
        end
        ring_req = ring_req && pwr_mode_r[PM_RING_SEL];
    end

    // Wake latch: a new ring wins over a clearing host cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ring_latched_r <= 1'b0;
        end
        else if (ring_req)
        begin
            ring_latched_r <= 1'b1;
        end
        else if (host_cycle_start || !pwr_mode_r[PM_RING_SEL])
        begin
            ring_latched_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            interrupt_pin_fifteen_out <= 1'b0;
            interrupt_pin_fifteen_oe_n <= 1'b1;
        end
        else if (pwr_mode_r[PM_RING_SEL])
        begin
            interrupt_pin_fifteen_out <= !ring_latched_r;
            interrupt_pin_fifteen_oe_n <= 1'b0;
        end
        else
        begin
            interrupt_pin_fifteen_out <= interrupt_pin_fifteen_req;
            interrupt_pin_fifteen_oe_n <= 1'b0;
        end
    end

    // Idle hold count
    logic activity;

    assign activity = card_bus_busy || (|strb) || (|inserted) || (|removed);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            idle_cnt_r <= IDLE_HOLD;
        end
        else if (activity || state_r != PS_ACTIVE)
        begin
            idle_cnt_r <= IDLE_HOLD;
        end
        else if (idle_cnt_r != '0)
        begin
            idle_cnt_r <= idle_cnt_r - 1'b1;
        end
    end

    // Power state machine
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PS_ACTIVE:
            begin
                if (pwr_mode_r[PM_SUSPEND])
                begin
                    state_nxt = PS_SUSPEND;
                end
                else if (pwr_mode_r[PM_IDLE_EN] && idle_cnt_r == '0 && !activity)
                begin
                    state_nxt = PS_GATED;
                end
            end
            PS_GATED:
            begin
                if (pwr_mode_r[PM_SUSPEND])
                begin
                    state_nxt = PS_SUSPEND;
                end
                else if (activity || !pwr_mode_r[PM_IDLE_EN])
                begin
                    state_nxt = PS_ACTIVE;
                end
            end
            PS_SUSPEND:
            begin
                if (!pwr_mode_r[PM_SUSPEND])
                begin
                    state_nxt = PS_WAKING;
                end
            end
            PS_WAKING:
            begin
                if (pwr_mode_r[PM_SUSPEND])
                begin
                    state_nxt = PS_SUSPEND;
                end
                else if (wake_cnt_r == '0)
                begin
                    state_nxt = PS_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_r <= PS_ACTIVE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Synthesizer restart delay after suspend
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wake_cnt_r <= '0;
        end
        else if (state_r == PS_SUSPEND)
        begin
            wake_cnt_r <= WAKE_CYCLES - 1'b1;
        end
        else if (state_r == PS_WAKING && wake_cnt_r != '0)
        begin
            wake_cnt_r <= wake_cnt_r - 1'b1;
        end
    end

    // Clock gate and card side controls
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            core_clk_en <= 1'b1;
            card_access_en <= 1'b1;
            card_lines_hold <= 1'b0;
        end
        else
        begin
            core_clk_en <= state_nxt == PS_ACTIVE;
            card_access_en <= (state_nxt == PS_ACTIVE || state_nxt == PS_GATED)
                              && bus_open;
            card_lines_hold <= state_nxt != PS_ACTIVE;
        end
    end

    // Register read mux
    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        logic [7:0] d;
        d = 8'h00;
        if (idx == IDX_PWR_MODE)
        begin
            d = pwr_mode_r;
        end
        for (int s = 0; s < NSOCK; s++)
        begin
            if (sock_hit(idx, s, IDX_CARD_CTRL))
            begin
                d = card_ctrl_r[s];
            end
            if (sock_hit(idx, s, IDX_SOCK_PWR))
            begin
                d = sock_pwr_r[s];
            end
            if (sock_hit(idx, s, IDX_SOCK_STAT))
            begin
                d = {3'h0, ring_latched_r, sock_f[s].volt_sense,
                     !sock_f[s].card_status_ring_input_n, present[s]};
            end
        end
        return d;
    endfunction

    // Host read data: index always, data port only while registers are open
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sd_out <= 8'h00;
            sd_oe_n <= 1'b1;
        end
        else if (rd_port && hit_idx)
        begin
            sd_out <= index_r;
            sd_oe_n <= 1'b0;
        end
        else if (rd_port && regs_open)
        begin
            sd_out <= reg_read(index_r);
            sd_oe_n <= 1'b0;
        end
        else
        begin
            sd_out <= 8'h00;
            sd_oe_n <= 1'b1;
        end
    end

endmodule

/* logic/pmrw_pkg.sv */
// Constants, register map and carrier types for the power mode and ring wake block.
// Assumes a single 50 MHz clock and an indexed 8-bit register scheme on the host bus.
package pmrw_pkg;

    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int WAKE_MS = 50;
    localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
    localparam int WAKE_W = 22;
    localparam logic [WAKE_W-1:0] WAKE_CYC_DEF = WAKE_CYC[WAKE_W-1:0];
    localparam int IDLE_W = 5;
    localparam logic [IDLE_W-1:0] IDLE_HOLD = 5'h10;

    // Sockets
    localparam int NSOCK = 2;
    localparam logic [7:0] SOCK_STRIDE = 8'h40;

    // Host I/O ports of the index scheme
    localparam int SA_W = 10;
    localparam logic [SA_W-1:0] PORT_INDEX = 10'h03e0;
    localparam logic [SA_W-1:0] PORT_DATA = 10'h03e1;

    // Register indexes
    localparam logic [7:0] IDX_SOCK_STAT = 8'h01;
    localparam logic [7:0] IDX_SOCK_PWR = 8'h02;
    localparam logic [7:0] IDX_CARD_CTRL = 8'h03;
    localparam logic [7:0] IDX_PWR_MODE = 8'h1e;

    // Power mode control fields
    localparam int PM_RING_SEL = 7;
    localparam int PM_SUSPEND = 2;
    localparam int PM_IDLE_EN = 1;
    localparam logic [7:0] PM_RESET = 8'h02;

    // Card interrupt and general control fields
    localparam int CC_RING_EN = 7;
    localparam int CC_IO_CARD = 5;
    localparam int CC_IRQ_LSB = 0;
    localparam logic [3:0] IRQ_SEL_FIFTEEN = 4'hf;
    localparam logic [7:0] CC_RESET = 8'h00;

    // Socket power fields
    localparam int SP_VCC_LSB = 0;
    localparam int SP_VPP_LSB = 2;
    localparam int SP_AUTO = 4;
    localparam logic [1:0] VCC_AUTO_ON = 2'h1;
    localparam logic [7:0] SP_RESET = 8'h00;

    // Power states
    typedef enum logic [1:0] {PS_ACTIVE, PS_GATED, PS_SUSPEND, PS_WAKING} pmrw_pwr_e;

    // Host bus pins, sampled
    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
        logic aen;
        logic [SA_W-1:0] sa;
        logic [7:0] sd;
    } pmrw_isa_in_s;

    // Six pins per socket: four supply controls, two sense inputs
    typedef struct packed {
        logic card_detect_n;
        logic card_status_ring_input_n;
        logic card_irq_n;
        logic [1:0] volt_sense;
    } pmrw_sock_in_s;

    typedef struct packed {
        logic [1:0] vcc_en;
        logic [1:0] vpp_en;
    } pmrw_sock_out_s;

endpackage

/* logic/pmrw_pin_filter.sv */
// Three-stage input filter for pins from outside the clock domain.
// Assumes idle pin level is high; output follows once stages two and three agree.
`timescale 1ns/1ns
module pmrw_pin_filter #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Synchroniser chain
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Take a bit only where the last two stages agree
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            dout <= '1;
        end
        else
        begin
            dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
        end
    end

endmodule

/* bench/pmrw_sva.sv */
// Checker for the power mode and ring wake top.
// Assumes binding to pmrw_top and sight of its ports only.
`timescale 1ns/1ns
module pmrw_sva #(
    parameter logic [pmrw_pkg::WAKE_W-1:0] WAKE_CYCLES = pmrw_pkg::WAKE_CYC_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Host bus
    input wire pmrw_pkg::pmrw_isa_in_s isa_in,
    input wire logic [7:0] sd_out,
    input wire logic sd_oe_n,
    // Pin fifteen
    input wire logic interrupt_pin_fifteen_out,
    input wire logic interrupt_pin_fifteen_oe_n,
    // Sockets
    input wire pmrw_pkg::pmrw_sock_in_s [pmrw_pkg::NSOCK-1:0] sock_in,
    input wire pmrw_pkg::pmrw_sock_out_s [pmrw_pkg::NSOCK-1:0] sock_out,
    // Card side
    input wire logic card_bus_busy,
    input wire logic core_clk_en,
    input wire logic card_access_en,
    input wire logic card_lines_hold
);
    import pmrw_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    pin_driven_a: assert property ($fell(sys_rst) |=> !interrupt_pin_fifteen_oe_n)
        else $error("pin fifteen not driven after reset");
    idle_gate_a: assert property ($fell(sys_rst) |-> core_clk_en[*8] ##[5:20] !core_clk_en)
        else $error("idle gating not entered");
    hold_clk_a: assert property (card_lines_hold == !core_clk_en)
        else $error("card lines hold disagrees with clock");
    idle_entry_a: assert property ($rose(card_lines_hold) && card_access_en
        |-> !$past(card_bus_busy) && !$past(card_bus_busy, 2))
        else $error("gated while card bus busy");
    busy_wake_a: assert property (card_bus_busy && card_access_en
        |=> core_clk_en || !card_access_en)
        else $error("card activity did not wake");
    no_read_drive_a: assert property (isa_in.ior_n[*8] |-> sd_oe_n)
        else $error("data bus driven without read");
    read_stable_a: assert property (!sd_oe_n && $past(!sd_oe_n) |-> $stable(sd_out))
        else $error("read data moved while driven");
    aen_block_a: assert property (isa_in.aen[*7] |-> sd_oe_n && !card_access_en)
        else $error("bus not blocked under address enable");
    sock0_off_a: assert property (sock_in[0].card_detect_n[*8] |-> sock_out[0] == 4'h0)
        else $error("empty socket zero powered");
    sock1_off_a: assert property (sock_in[1].card_detect_n[*8] |-> sock_out[1] == 4'h0)
        else $error("empty socket one powered");
endmodule

bind pmrw_top pmrw_sva #(.WAKE_CYCLES(WAKE_CYCLES)) u_sva (.mclk(mclk), .sys_rst(sys_rst),
    .isa_in(isa_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
    .interrupt_pin_fifteen_out(interrupt_pin_fifteen_out),
    .interrupt_pin_fifteen_oe_n(interrupt_pin_fifteen_oe_n), .sock_in(sock_in),
    .sock_out(sock_out), .card_bus_busy(card_bus_busy), .core_clk_en(core_clk_en),
    .card_access_en(card_access_en), .card_lines_hold(card_lines_hold));

/* bench/pmrw_host_model.sv */
// Host bus model: indexed I/O cycles and address enable.
// Assumes the bench calls its tasks; pins change at the falling edge.
`timescale 1ns/1ns
module pmrw_host_model (
    // Clock
    input wire logic mclk,
    // Host bus
    output pmrw_pkg::pmrw_isa_in_s isa_in,
    input wire logic [7:0] sd_out,
    input wire logic sd_oe_n
);
    import pmrw_pkg::*;
    logic [7:0] last_r;

    initial
    begin
        last_r = 8'h00;
        isa_in = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, PORT_INDEX, 8'hff};
    end

    task cyc(input logic rd, input logic [SA_W-1:0] a, input logic [7:0] wd,
             output logic [7:0] rdat, output logic drv);
        @(negedge mclk);
        isa_in.sa = a;
        isa_in.sd = rd ? ~last_r : wd;
        @(negedge mclk);
        if (rd)
            isa_in.ior_n = 1'b0;
        else
            isa_in.iow_n = 1'b0;
        repeat (8) @(posedge mclk);
        rdat = sd_out;
        drv = !sd_oe_n;
        @(negedge mclk);
        isa_in.ior_n = 1'b1;
        isa_in.iow_n = 1'b1;
        last_r = rd ? rdat : wd;
        @(negedge mclk);
        // Released bus drifts away from its last value
        isa_in.sd = ~last_r;
        repeat (5) @(negedge mclk);
    endtask

    // Memory read strobe alone, no data taken
    task mem_rd;
        @(negedge mclk);
        isa_in.memr_n = 1'b0;
        repeat (8) @(negedge mclk);
        isa_in.memr_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask

    task set_aen(input logic v);
        @(negedge mclk);
        isa_in.aen = v;
        repeat (8) @(negedge mclk);
    endtask
endmodule

/* bench/pmrw_tb_top.sv */
// Testbench for the power mode and ring wake top.
// Assumes the host model drives the bus; shortened restart delay.
`timescale 1ns/1ns
module pmrw_tb_top;
    import pmrw_pkg::*;
    localparam logic [WAKE_W-1:0] WAKE_SIM = 22'h00_0014;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    pmrw_isa_in_s isa_in;
    pmrw_sock_in_s [NSOCK-1:0] sock_in;
    pmrw_sock_out_s [NSOCK-1:0] sock_out;
    logic [7:0] sd_out;
    logic sd_oe_n, pin15, pin15_oe_n, busy, clk_en, acc_en, hold, dv;
    logic [7:0] rv, pat;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    pmrw_top #(.WAKE_CYCLES(WAKE_SIM)) dut (.mclk(mclk), .sys_rst(sys_rst), .isa_in(isa_in),
        .sd_out(sd_out), .sd_oe_n(sd_oe_n), .interrupt_pin_fifteen_out(pin15),
        .interrupt_pin_fifteen_oe_n(pin15_oe_n), .sock_in(sock_in), .sock_out(sock_out),
        .card_bus_busy(busy), .core_clk_en(clk_en), .card_access_en(acc_en),
        .card_lines_hold(hold));
    pmrw_host_model u_host (.mclk(mclk), .isa_in(isa_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n));

    function automatic logic ring_exp(input logic sel, input logic en, input logic ring_n);
        return !(sel && en && !ring_n);
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] v);
        u_host.cyc(1'b0, PORT_INDEX, idx, rv, dv);
        u_host.cyc(1'b0, PORT_DATA, v, rv, dv);
    endtask

    task rd(input logic [7:0] idx);
        u_host.cyc(1'b0, PORT_INDEX, idx, rv, dv);
        u_host.cyc(1'b1, PORT_DATA, 8'h00, rv, dv);
    endtask

    task ring_pulse;
        sock_in[0].card_status_ring_input_n = 1'b0;
        repeat (10) @(negedge mclk);
        sock_in[0].card_status_ring_input_n = 1'b1;
        repeat (12) @(negedge mclk);
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    initial
    begin
        sock_in = {NSOCK{5'h1f}};
        busy = 1'b0;
        void'($urandom(32'hf5fc6848));
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (40) @(negedge mclk);
        check({7'h0, clk_en}, 8'h00);
        check({7'h0, hold}, 8'h01);
        busy = 1'b1;
        repeat (2) @(negedge mclk);
        check({7'h0, clk_en}, 8'h01);
        busy = 1'b0;
        repeat (40) @(negedge mclk);
        check({7'h0, clk_en}, 8'h00);
        rd(IDX_PWR_MODE);
        check(rv, PM_RESET);
        check({7'h0, dv}, 8'h01);
        rd(8'h3f);
        check(rv, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            pat = 8'($urandom);
            wr(IDX_CARD_CTRL + SOCK_STRIDE, pat);
            rd(IDX_CARD_CTRL + SOCK_STRIDE);
            check(rv, pat);
        end
        wr(IDX_CARD_CTRL + SOCK_STRIDE, 8'h00);
        wr(IDX_PWR_MODE, 8'h00);
        repeat (40) @(negedge mclk);
        check({7'h0, clk_en}, 8'h01);
        $display("test registers and idle done");
        wr(IDX_SOCK_PWR, 8'h10);
        sock_in[0].card_detect_n = 1'b0;
        repeat (8) @(negedge mclk);
        check({4'h0, sock_out[0]}, {4'h0, VCC_AUTO_ON, 2'h0});
        wr(IDX_CARD_CTRL, 8'ha0);
        wr(IDX_PWR_MODE, 8'h80);
        ring_pulse();
        check({7'h0, pin15}, {7'h0, ring_exp(1'b1, 1'b1, 1'b0)});
        check({7'h0, pin15_oe_n}, 8'h00);
        u_host.cyc(1'b1, PORT_INDEX, 8'h00, rv, dv);
        check({7'h0, pin15}, 8'h01);
        ring_pulse();
        check({7'h0, pin15}, 8'h00);
        u_host.mem_rd();
        check({7'h0, pin15}, 8'h01);
        wr(IDX_CARD_CTRL, 8'h20);
        ring_pulse();
        check({7'h0, pin15}, {7'h0, ring_exp(1'b1, 1'b0, 1'b0)});
        wr(IDX_PWR_MODE, 8'h00);
        wr(IDX_CARD_CTRL, 8'h0f);
        sock_in[0].card_irq_n = 1'b0;
        repeat (10) @(negedge mclk);
        check({7'h0, pin15}, 8'h01);
        sock_in[0].card_irq_n = 1'b1;
        $display("test ring wake done");
        wr(IDX_CARD_CTRL, 8'ha0);
        wr(IDX_SOCK_PWR, 8'h00);
        wr(IDX_PWR_MODE, 8'h84);
        check({7'h0, clk_en}, 8'h00);
        check({7'h0, acc_en}, 8'h00);
        rd(IDX_PWR_MODE);
        check({7'h0, dv}, 8'h00);
        wr(IDX_CARD_CTRL, 8'h00);
        ring_pulse();
        check({7'h0, pin15}, 8'h00);
        u_host.cyc(1'b1, PORT_INDEX, 8'h00, rv, dv);
        check(rv, IDX_CARD_CTRL);
        wr(IDX_PWR_MODE, 8'h80);
        check({7'h0, clk_en}, 8'h00);
        repeat (20) @(negedge mclk);
        check({7'h0, clk_en}, 8'h01);
        rd(IDX_CARD_CTRL);
        check(rv, 8'ha0);
        $display("test suspend done");
        u_host.set_aen(1'b1);
        check({7'h0, acc_en}, 8'h00);
        u_host.cyc(1'b1, PORT_DATA, 8'h00, rv, dv);
        check({7'h0, dv}, 8'h00);
        ring_pulse();
        check({7'h0, pin15}, 8'h00);
        u_host.set_aen(1'b0);
        rd(IDX_PWR_MODE);
        check(rv, 8'h80);
        check({7'h0, acc_en}, 8'h01);
        $display("test address enable done");
        wr(IDX_SOCK_PWR, 8'h05);
        check({4'h0, sock_out[0]}, 8'h05);
        sock_in[0].card_detect_n = 1'b1;
        repeat (8) @(negedge mclk);
        check({4'h0, sock_out[0]}, 8'h00);
        $display("test socket power done");
        end_sim();
    end
endmodule
